// ==== core/srcs_core.sv ====
// system reset and bus clock sequencer
//
// Overview of operation
// - bus clock is reference or PLL clock divided by four.
// - power-on or low-voltage reset holds clocks 4096 reference cycles, pin low.
// - stop exit counts reference cycles before clocks restart.
// - wait mode stops CPU clock, peripheral clock keeps running.
// - every reset asserts internal reset, vector top pair or monitor pair.
// - internal reset returns registers to defaults.
// - internal resets clear the timing counter, pin reset leaves it alone.
// - each reset source sets its own cause bit.
// - pin must stay low 67 cycles, 4163 during power sequence.
// - internal reset drives pin 32 cycles, then holds reset 32 more.
// - after power-on count, release from reset 64 cycles later.
// - watchdog request is taken asynchronously and synchronised.
// - power-on sets power-on cause only, enables clock generator output.
// - watchdog overflow resets and sets cause unless watchdog disabled.
// - illegal opcode sets its cause bit and resets.
// - stop with stop disabled counts as illegal opcode.
// - opcode fetch or indexed/stack access to unmapped space resets.
// - enabled low-voltage detect resets, pin low until 4096 + 32 after recovery.
// - 12-bit counter on reference falling edge, overflow clocks watchdog.
// - cause register layout: 7 por, 6 pin, 5 wdog, 4, 3, 1.
// - clock generator output is on before stabilisation count starts.
// - break clear enable bit lets other modules clear flags in break.
// - break during wait sets break-during-wait status bit.
// - short stop recovery bit selects 32 cycles instead of 4096.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module srcs_core import srcs_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic osc_ref_clock_i,
	input wire logic pll_out_clock_i,
	input wire logic pll_select_i,
	input wire logic power_on_pulse_i,
	input wire logic low_voltage_detect_i,
	input wire logic watchdog_timeout_i,
	input wire logic cpu_irq_i,
	input wire logic break_irq_i,
	input wire logic rst_pin_i,
	input wire logic watchdog_disable_i,
	input wire logic low_voltage_power_disable_i,
	input wire logic low_voltage_reset_disable_i,
	input wire logic stop_enable_i,
	input wire logic short_stop_recovery_i,
	input wire logic monitor_mode_i,
	input wire logic illegal_opcode_i,
	input wire logic stop_instr_i,
	input wire logic wait_instr_i,
	input wire logic opcode_fetch_i,
	input wire logic indexed_stack_access_i,
	input wire logic unmapped_addr_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [7:0] reg_rdata_o,
	output logic rst_pin_o,
	output logic rst_pin_oe_o,
	output logic internal_reset_o,
	output logic clockgen_output_en_o,
	output logic cpu_clk_o,
	output logic periph_clk_o,
	output logic watchdog_tick_o,
	output logic [15:0] reset_vector_o,
	output logic break_clear_enable_o
);
	// synchronised asynchronous inputs
	logic [6:0] async_s;
	logic [0:0] pin_s;
	logic osc_s, pll_s, por_s, lvd_s, wdog_s, irq_s, brk_s;

	// state and counters
	srcs_state_t state_q, state_d;
	logic osc_prev_q, pll_prev_q;
	logic [SRCS_CNT_W-1:0] cnt_q;
	logic [5:0] stg_q;
	logic [12:0] pin_cnt_q;
	logic [1:0] div_q;
	logic long_seq_q;
	logic [7:0] cause_q;
	logic brk_wait_q;
	logic brk_clr_en_q;
	logic [1:0] oe_hist_q;

	// event and decode wires
	logic ref_fall, ref_rise, pll_rise, src_rise;
	logic cnt_last, stg_last, recov_done;
	logic req_lvd, req_long, req_wdog, req_badop, req_badadr, req_short;
	logic internal_reset_busy, pin_ext_low, wake, enter_int, enter_long;
	logic cnt_clr, pin_qual, stg_clr;
	logic sel_brk_stat, sel_cause, sel_brk_ctrl;
	logic [7:0] rdata_mux;
	logic [7:0] cause_short;

	// async inputs caught by two flip-flops
	srcs_sync #(.W(7), .RST_VAL(7'h00)) u_sync_lvl (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i({osc_ref_clock_i, pll_out_clock_i, power_on_pulse_i,
			low_voltage_detect_i, watchdog_timeout_i, cpu_irq_i,
			break_irq_i}),
		.q_o(async_s)
	);

	srcs_sync #(.W(1), .RST_VAL(1'b1)) u_sync_pin (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i(rst_pin_i),
		.q_o(pin_s)
	);

	assign {osc_s, pll_s, por_s, lvd_s, wdog_s, irq_s, brk_s} = async_s;

	// edge detection on the synchronised clocks
	assign ref_fall = osc_prev_q & ~osc_s;
	assign ref_rise = ~osc_prev_q & osc_s;
	assign pll_rise = ~pll_prev_q & pll_s;
	assign src_rise = pll_select_i ? pll_rise : ref_rise;

	// low-voltage reset only with both disables clear
	assign req_lvd = lvd_s & ~low_voltage_power_disable_i &
		~low_voltage_reset_disable_i;
	assign req_long = por_s | req_lvd;
	// watchdog request gated by its disable
	assign req_wdog = wdog_s & ~watchdog_disable_i;
	// stop while stop disabled is an illegal opcode
	assign req_badop = illegal_opcode_i | (stop_instr_i & ~stop_enable_i);
	// fetch or indexed/stack access to unmapped space
	assign req_badadr = unmapped_addr_i &
		(opcode_fetch_i | indexed_stack_access_i);
	assign req_short = req_wdog | req_badop | req_badadr;

	// sequencer status terms
	assign internal_reset_busy = (state_q == SRCS_ST_LONG) |
		(state_q == SRCS_ST_PIN) | (state_q == SRCS_ST_HOLD);
	// own drive is masked while the pin synchroniser still shows it
	assign pin_ext_low = ~pin_s[0] & ~rst_pin_oe_o & ~(|oe_hist_q);
	assign wake = irq_s | brk_s | pin_ext_low;
	assign cnt_last = ref_fall & (cnt_q == SRCS_LONG_LAST);
	assign stg_last = ref_fall &
		(stg_q == 6'(SRCS_PIN_DRIVE_CYC - 1));
	// short recovery selects the 32 cycle count
	assign recov_done = ref_fall & (short_stop_recovery_i ?
		(cnt_q == SRCS_SHORT_LAST) : (cnt_q == SRCS_LONG_LAST));

	// next state of the reset and low-power sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			SRCS_ST_RUN: begin
				if (req_short) begin
					state_d = SRCS_ST_PIN;
				end else if (pin_ext_low) begin
					state_d = SRCS_ST_EXT;
				end else if (stop_instr_i & stop_enable_i) begin
					state_d = SRCS_ST_STOP;
				end else if (wait_instr_i) begin
					state_d = SRCS_ST_WAIT;
				end
			end
			// long count with pin low, then 64 more
			SRCS_ST_LONG: begin
				if (cnt_last & ~req_long) begin
					state_d = SRCS_ST_PIN;
				end
			end
			// pin driven for the first 32 cycles
			SRCS_ST_PIN: begin
				if (stg_last) begin
					state_d = SRCS_ST_HOLD;
				end
			end
			// internal reset held 32 cycles more
			SRCS_ST_HOLD: begin
				if (pin_ext_low) begin
					state_d = SRCS_ST_EXT;
				end else if (stg_last) begin
					state_d = SRCS_ST_RUN;
				end
			end
			SRCS_ST_EXT: begin
				if (req_short) begin
					state_d = SRCS_ST_PIN;
				end else if (pin_s[0]) begin
					state_d = SRCS_ST_HOLD;
				end
			end
			// stop exit by interrupt, break or reset
			SRCS_ST_STOP: begin
				if (wake) begin
					state_d = SRCS_ST_RECOV;
				end
			end
			SRCS_ST_RECOV: begin
				if (recov_done) begin
					state_d = pin_ext_low ? SRCS_ST_EXT : SRCS_ST_RUN;
				end
			end
			SRCS_ST_WAIT: begin
				if (req_short) begin
					state_d = SRCS_ST_PIN;
				end else if (pin_ext_low) begin
					state_d = SRCS_ST_EXT;
				end else if (irq_s | brk_s) begin
					state_d = SRCS_ST_RUN;
				end
			end
			default: begin
				state_d = SRCS_ST_LONG;
			end
		endcase
		// power-on or low voltage restarts the long count
		if (req_long) begin
			state_d = SRCS_ST_LONG;
		end
	end

	// entry into an internally sourced reset
	assign enter_long = req_long & (state_q != SRCS_ST_LONG);
	assign enter_int = enter_long | ((state_d == SRCS_ST_PIN) &
		((state_q == SRCS_ST_RUN) | (state_q == SRCS_ST_WAIT) |
		(state_q == SRCS_ST_EXT)));
	// only internal resets and stop clear the counter
	assign cnt_clr = enter_int | (state_q == SRCS_ST_STOP) |
		((state_q == SRCS_ST_LONG) & req_long);
	assign stg_clr = state_d != state_q;
	assign pin_qual = ref_fall & ~pin_s[0] & (pin_cnt_q ==
		(long_seq_q ? SRCS_PIN_QUAL_LONG : SRCS_PIN_QUAL) - 13'h0001);

	// state, edge history and sequence flag
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= SRCS_ST_LONG;
			osc_prev_q <= 1'b0;
			pll_prev_q <= 1'b0;
			long_seq_q <= 1'b1;
			oe_hist_q <= 2'b11;
		end else begin
			state_q <= state_d;
			oe_hist_q <= {oe_hist_q[0], rst_pin_oe_o}; // pin drive history
			osc_prev_q <= osc_s;
			pll_prev_q <= pll_s;
			long_seq_q <= (state_d == SRCS_ST_LONG) |
				(long_seq_q & (state_d != SRCS_ST_RUN));
		end
	end

	// 12-bit counter on the reference falling edge
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= '0;
		end else if (cnt_clr) begin
			cnt_q <= '0;
		end else if (ref_fall) begin
			cnt_q <= cnt_q + 12'h001;
		end
	end

	// stage counter for the 32 cycle phases
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stg_q <= '0;
		end else if (stg_clr) begin
			stg_q <= '0;
		end else if (ref_fall) begin
			stg_q <= stg_q + 6'h01;
		end
	end

	// count reference cycles while the pin reads low
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_cnt_q <= '0;
		end else if (pin_s[0]) begin
			pin_cnt_q <= '0;
		end else if (ref_fall & (pin_cnt_q != 13'h1fff)) begin
			pin_cnt_q <= pin_cnt_q + 13'h0001;
		end
	end

	// cause bits for a watchdog, opcode or address reset
	always_comb begin
		cause_short = 8'h00;
		cause_short[SRCS_CAUSE_WDOG] = req_wdog;
		cause_short[SRCS_CAUSE_BADOP] = req_badop;
		cause_short[SRCS_CAUSE_BADADR] = req_badadr;
	end

	// reset cause register, last origin kept
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			// power-on sets only its own bit
			cause_q <= SRCS_CAUSE_RST;
		end else if (enter_long) begin
			cause_q <= por_s ? SRCS_CAUSE_RST :
				(8'h01 << SRCS_CAUSE_LVD);
		end else if (enter_int) begin
			cause_q <= cause_short;
		end else if ((state_d == SRCS_ST_EXT) &
			(state_q != SRCS_ST_EXT) & ~long_seq_q) begin
			cause_q <= 8'h00;
		end else if (pin_qual) begin
			cause_q[SRCS_CAUSE_PIN] <= 1'b1;
		end
	end

	// register decode and read mux
	assign sel_brk_stat = reg_addr_i == SRCS_OFF_BRK_STAT;
	assign sel_cause = reg_addr_i == SRCS_OFF_RST_CAUSE;
	assign sel_brk_ctrl = reg_addr_i == SRCS_OFF_BRK_CTRL;
	assign rdata_mux = sel_brk_stat ? {6'h00, brk_wait_q, 1'b0} :
		sel_cause ? cause_q :
		sel_brk_ctrl ? {brk_clr_en_q, 7'h00} : 8'h00;

	// break registers, reset while internal reset is asserted
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			brk_wait_q <= SRCS_BRK_STAT_RST[SRCS_BRK_WAIT_BIT];
			brk_clr_en_q <= SRCS_BRK_CLR_EN_RST;
		end else if (internal_reset_o) begin
			brk_wait_q <= SRCS_BRK_STAT_RST[SRCS_BRK_WAIT_BIT];
			brk_clr_en_q <= SRCS_BRK_CLR_EN_RST;
		end else begin
			// break in wait sets, set beats a clear
			if (brk_s & (state_q == SRCS_ST_WAIT)) begin
				brk_wait_q <= 1'b1;
			end else if (reg_we_i & sel_brk_stat &
				~reg_wdata_i[SRCS_BRK_WAIT_BIT]) begin
				brk_wait_q <= 1'b0;
			end
			// break clear enable written by software
			if (reg_we_i & sel_brk_ctrl) begin
				brk_clr_en_q <= reg_wdata_i[SRCS_BRK_CLR_EN_BIT];
			end
		end
	end

	// read data stands one cycle after the strobe
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= reg_re_i ? rdata_mux : 8'h00;
		end
	end

	// divide the selected source by four
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_q <= 2'b00;
		end else if (src_rise) begin
			div_q <= div_q + 2'b01;
		end
	end

	// registered outputs of the sequencer
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_pin_o <= 1'b0;
			rst_pin_oe_o <= 1'b1;
			internal_reset_o <= 1'b1;
			clockgen_output_en_o <= 1'b1;
			cpu_clk_o <= 1'b0;
			periph_clk_o <= 1'b0;
			watchdog_tick_o <= 1'b0;
			reset_vector_o <= SRCS_VEC_USER;
			break_clear_enable_o <= SRCS_BRK_CLR_EN_RST;
		end else begin
			rst_pin_o <= 1'b0;
			// pin driven in long and pin phases
			rst_pin_oe_o <= (state_d == SRCS_ST_LONG) |
				(state_d == SRCS_ST_PIN);
			internal_reset_o <= (state_d == SRCS_ST_LONG) |
				(state_d == SRCS_ST_PIN) | (state_d == SRCS_ST_HOLD) |
				(state_d == SRCS_ST_EXT);
			// clock generator output on except in stop
			clockgen_output_en_o <= state_d != SRCS_ST_STOP;
			cpu_clk_o <= div_q[1] & (state_q == SRCS_ST_RUN);
			periph_clk_o <= div_q[1] & ((state_q == SRCS_ST_RUN) |
				(state_q == SRCS_ST_WAIT));
			watchdog_tick_o <= cnt_last;
			// vector pair chosen by monitor mode
			reset_vector_o <= monitor_mode_i ? SRCS_VEC_MON :
				SRCS_VEC_USER;
			break_clear_enable_o <= brk_clr_en_q;
		end
	end
endmodule : srcs_core

// ==== core/srcs_pkg.sv ====
// constants shared by the reset and clock sequencer
package srcs_pkg;
	// register byte offsets on the register port
	localparam logic [15:0] SRCS_OFF_BRK_STAT = 16'hfe00;
	localparam logic [15:0] SRCS_OFF_RST_CAUSE = 16'hfe01;
	localparam logic [15:0] SRCS_OFF_BRK_CTRL = 16'hfe03;
	// reset cause bit positions
	localparam int SRCS_CAUSE_POR = 7;
	localparam int SRCS_CAUSE_PIN = 6;
	localparam int SRCS_CAUSE_WDOG = 5;
	localparam int SRCS_CAUSE_BADOP = 4;
	localparam int SRCS_CAUSE_BADADR = 3;
	localparam int SRCS_CAUSE_LVD = 1;
	// break register bit positions
	localparam int SRCS_BRK_WAIT_BIT = 1;
	localparam int SRCS_BRK_CLR_EN_BIT = 7;
	// reset values
	localparam logic [7:0] SRCS_CAUSE_RST = 8'h80;
	localparam logic [7:0] SRCS_BRK_STAT_RST = 8'h00;
	localparam logic SRCS_BRK_CLR_EN_RST = 1'b0;
	// reset vectors
	localparam logic [15:0] SRCS_VEC_USER = 16'hfffe;
	localparam logic [15:0] SRCS_VEC_MON = 16'hfefe;
	// timing counts in oscillator reference cycles
	localparam int SRCS_CNT_W = 12;
	localparam logic [11:0] SRCS_LONG_LAST = 12'hfff;
	localparam logic [11:0] SRCS_SHORT_LAST = 12'h01f;
	localparam int SRCS_PIN_DRIVE_CYC = 32;
	localparam int SRCS_HOLD_CYC = 32;
	localparam logic [12:0] SRCS_PIN_QUAL = 13'h0043;
	localparam logic [12:0] SRCS_PIN_QUAL_LONG = 13'h1043;
	// sequencer states, one-hot
	typedef enum logic [7:0] {
		SRCS_ST_RUN = 8'h01,
		SRCS_ST_LONG = 8'h02,
		SRCS_ST_PIN = 8'h04,
		SRCS_ST_HOLD = 8'h08,
		SRCS_ST_EXT = 8'h10,
		SRCS_ST_STOP = 8'h20,
		SRCS_ST_RECOV = 8'h40,
		SRCS_ST_WAIT = 8'h80
	} srcs_state_t;
endpackage : srcs_pkg

// ==== core/srcs_sync.sv ====
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module srcs_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule : srcs_sync

// ==== tb/srcs_core_sva.sv ====
// port checks for the reset and clock sequencer
`timescale 1ns/10ps
module srcs_core_sva import srcs_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic illegal_opcode_i,
	input wire logic opcode_fetch_i,
	input wire logic unmapped_addr_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic rst_pin_oe_o,
	input wire logic internal_reset_o,
	input wire logic clockgen_output_en_o,
	input wire logic break_clear_enable_o,
	input wire logic watchdog_tick_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// write data bit that lands in the break clear enable
	wire wbit = reg_wdata_i[SRCS_BRK_CLR_EN_BIT];
	a_opcode_reset: assert property (
		(illegal_opcode_i && !internal_reset_o) |=>
		(internal_reset_o && rst_pin_oe_o))
		else $error("bad opcode did not start reset");
	a_badaddr_reset: assert property (
		(opcode_fetch_i && unmapped_addr_i && !internal_reset_o) |=>
		rst_pin_oe_o)
		else $error("unmapped fetch did not drive the pin");
	a_pin_in_reset: assert property (
		rst_pin_oe_o |-> internal_reset_o)
		else $error("pin driven without internal reset");
	a_hold_after_pin: assert property (
		$fell(rst_pin_oe_o) |-> internal_reset_o [*8])
		else $error("internal reset dropped with the pin");
	a_cause_zero_bits: assert property (
		(reg_re_i && reg_addr_i == SRCS_OFF_RST_CAUSE) |=>
		(reg_rdata_o[2] == 1'b0 && reg_rdata_o[0] == 1'b0))
		else $error("reserved cause bits not zero");
	a_clr_en_copy: assert property (
		(reg_we_i && reg_addr_i == SRCS_OFF_BRK_CTRL && !internal_reset_o)
		|=> ##1 break_clear_enable_o == $past(wbit, 2))
		else $error("break clear enable not taken from write");
	a_clkgen_on: assert property (
		rst_pin_oe_o |-> clockgen_output_en_o)
		else $error("clock generator off during reset count");
	a_tick_pulse: assert property (
		watchdog_tick_o |=> !watchdog_tick_o)
		else $error("watchdog tick longer than one cycle");
	c_pin_release: cover property ($fell(rst_pin_oe_o));
	c_opcode: cover property (illegal_opcode_i && !internal_reset_o);
	c_tick: cover property (watchdog_tick_o);
endmodule : srcs_core_sva
bind srcs_core srcs_core_sva u_sva (.*);

// ==== tb/srcs_far_model.sv ====
// far side model: reference and pll oscillators, reset pin wire
`timescale 1ns/10ps
module srcs_far_model (
	input wire logic rst_pin_oe_i,
	input wire logic pin_val_i,
	input wire logic ext_pin_low_i,
	output logic osc_ref_clock_o,
	output logic pll_out_clock_o,
	output logic rst_pin_o
);
	// free running oscillators, kept off the bench clock edges
	initial begin
		osc_ref_clock_o = 1'b1;
		#1;
		forever #8 osc_ref_clock_o = ~osc_ref_clock_o;
	end
	initial begin
		pll_out_clock_o = 1'b0;
		#1;
		forever #12 pll_out_clock_o = ~pll_out_clock_o;
	end
	assign rst_pin_o = rst_pin_oe_i ? pin_val_i : ~ext_pin_low_i;
endmodule : srcs_far_model

// ==== tb/testbench.sv ====
// self-checking bench for the reset and clock sequencer
`timescale 1ns/10ps
module testbench import srcs_pkg::*; ;
	bit clk_i, rst_b_i, pll_select_i, power_on_pulse_i, low_voltage_detect_i;
	bit watchdog_timeout_i, cpu_irq_i, break_irq_i, watchdog_disable_i;
	bit low_voltage_power_disable_i, low_voltage_reset_disable_i;
	bit stop_enable_i, short_stop_recovery_i, monitor_mode_i;
	bit illegal_opcode_i, stop_instr_i, wait_instr_i, opcode_fetch_i;
	bit indexed_stack_access_i, unmapped_addr_i, reg_we_i, reg_re_i;
	bit [15:0] reg_addr_i;
	bit [7:0] reg_wdata_i;
	bit [5:0] cpu_p;
	bit [3:0] async_p;
	bit ext_low;
	logic osc_ref_clock_i, pll_out_clock_i, rst_pin_i;
	logic [7:0] reg_rdata_o;
	logic rst_pin_o, rst_pin_oe_o, internal_reset_o, clockgen_output_en_o;
	logic cpu_clk_o, periph_clk_o, watchdog_tick_o, break_clear_enable_o;
	logic [15:0] reset_vector_o;
	int errors, compares, refs, cpu_rises, per_rises, ticks;
	localparam logic [15:0] RA [4] = '{16'hfe00, 16'hfe01, 16'hfe02, 16'hfe03};
	localparam logic [7:0] RV [4] = '{8'h00, 8'h80, 8'h00, 8'h00};
	localparam logic [5:0] VP [4] = '{6'h01, 6'h02, 6'h28, 6'h30};
	localparam logic [7:0] VC [4] = '{8'h10, 8'h10, 8'h08, 8'h08};
	wire logic [3:0] obs = {cpu_clk_o, clockgen_output_en_o, rst_pin_oe_o,
		internal_reset_o};
	// cpu pulses and asynchronous requests from two small vectors
	assign {unmapped_addr_i, indexed_stack_access_i, opcode_fetch_i,
		wait_instr_i, stop_instr_i, illegal_opcode_i} = cpu_p;
	assign {break_irq_i, cpu_irq_i, watchdog_timeout_i,
		low_voltage_detect_i} = async_p;
	always #2 clk_i = ~clk_i;
	always @(negedge osc_ref_clock_i) refs++;
	always @(posedge cpu_clk_o) cpu_rises++;
	always @(posedge periph_clk_o) per_rises++;
	always @(posedge watchdog_tick_o) ticks++;
	srcs_core DUT (.*);
	srcs_far_model u_far (
		.rst_pin_oe_i(rst_pin_oe_o),
		.pin_val_i(rst_pin_o),
		.ext_pin_low_i(ext_low),
		.osc_ref_clock_o(osc_ref_clock_i),
		.pll_out_clock_o(pll_out_clock_i),
		.rst_pin_o(rst_pin_i)
	);
	task automatic end_sim();
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	task automatic check(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	function automatic logic near(input int v, input int e, input int t);
		return v >= e - 1 && v <= e + t;
	endfunction : near
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		@(negedge clk_i);
		d = reg_rdata_o;
	endtask : rd
	task automatic fire(input logic [5:0] v);
		@(posedge clk_i);
		cpu_p <= v;
		@(posedge clk_i);
		cpu_p <= 6'h00;
	endtask : fire
	task automatic apl(input logic [3:0] v, input int n);
		@(posedge clk_i);
		async_p <= v;
		repeat (n) @(posedge clk_i);
		async_p <= 4'h0;
	endtask : apl
	// bounded wait for one observed output to reach a level
	task automatic wait_sig(input int w, input logic v, input int lim);
		int n;
		n = 0;
		while (obs[w] !== v && n < lim) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= lim) begin
			errors++;
			end_sim();
		end
	endtask : wait_sig
	// pin phase, hold phase and cause of one reset
	task automatic seq(input logic [7:0] c, input int n, input int s);
		logic [7:0] d;
		int r;
		wait_sig(1, 1'b0, 20000);
		check("pin drive len", near(refs - s, n, 2), 1'b1);
		r = refs;
		wait_sig(0, 1'b0, 1000);
		check("hold len", near(refs - r, 32, 2), 1'b1);
		rd(SRCS_OFF_RST_CAUSE, d);
		check("cause", d, c);
	endtask : seq
	task automatic irs(input logic [5:0] v, input logic [7:0] c);
		int s;
		s = refs;
		fire(v);
		@(negedge clk_i);
		check("reset start", {internal_reset_o, rst_pin_oe_o}, 2'b11);
		seq(c, 32, s);
	endtask : irs
	initial begin
		logic [7:0] d;
		int s;
		int c;
		int p;
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		s = refs;
		@(negedge clk_i);
		check("power on", obs[2:0], 3'b111);
		seq(SRCS_CAUSE_RST, 4128, s);
		check("wdog tick", ticks, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			rd(RA[i], d);
			check("reset value", d, RV[i]);
		end
		wr(SRCS_OFF_RST_CAUSE, 8'hff);
		wr(SRCS_OFF_BRK_CTRL, 8'hff);
		wr(16'hfe02, 8'hff);
		rd(SRCS_OFF_RST_CAUSE, d);
		check("cause read only", d, SRCS_CAUSE_RST);
		rd(SRCS_OFF_BRK_CTRL, d);
		check("clear enable", {d, break_clear_enable_o}, 9'h101);
		for (int i = 0; i < 4; i++)
			irs(VP[i], VC[i]);
		rd(SRCS_OFF_BRK_CTRL, d);
		check("ctrl after reset", d, 8'h00);
		fire(6'h20);
		fire(6'h08);
		repeat (12) @(negedge clk_i);
		check("no reset", internal_reset_o, 1'b0);
		for (int i = 1; i >= 0; i--) begin
			@(posedge clk_i);
			monitor_mode_i <= i[0];
			repeat (3) @(negedge clk_i);
			check("vector", reset_vector_o,
				i[0] ? SRCS_VEC_MON : SRCS_VEC_USER);
		end
		@(posedge clk_i);
		watchdog_disable_i <= 1'b1;
		apl(4'h2, 4);
		repeat (12) @(negedge clk_i);
		check("wdog off", internal_reset_o, 1'b0);
		@(posedge clk_i);
		watchdog_disable_i <= 1'b0;
		s = refs;
		apl(4'h2, 4);
		seq(8'h20, 32, s);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i);
			{low_voltage_power_disable_i, low_voltage_reset_disable_i} <=
				2'b10 >> i;
			apl(4'h1, 80);
			s = refs;
			repeat (2) @(negedge clk_i);
			check("lvd reset", internal_reset_o, i == 2);
		end
		seq(8'h02, 4128, s);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			ext_low <= 1'b1;
			repeat (60 + 10 * i) @(negedge osc_ref_clock_i);
			check("pin reset", {internal_reset_o, rst_pin_oe_o}, 2'b10);
			@(posedge clk_i);
			ext_low <= 1'b0;
			wait_sig(0, 1'b0, 1000);
			rd(SRCS_OFF_RST_CAUSE, d);
			check("pin cause", d, i ? 8'h40 : 8'h00);
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			pll_select_i <= i[0];
			repeat (16) @(negedge clk_i);
			c = cpu_rises;
			repeat (768) @(negedge clk_i);
			check("bus rate", near(cpu_rises - c, 48 - 16 * i, 1), 1'b1);
		end
		@(posedge clk_i);
		pll_select_i <= 1'b0;
		fire(6'h04);
		repeat (8) @(negedge clk_i);
		c = cpu_rises;
		p = per_rises;
		repeat (64) @(negedge clk_i);
		check("wait cpu", cpu_rises - c, 16'h0000);
		check("wait periph", per_rises - p > 0, 1'b1);
		apl(4'h8, 4);
		rd(SRCS_OFF_BRK_STAT, d);
		check("break in wait", d, 8'h02);
		wr(SRCS_OFF_BRK_STAT, 8'h00);
		rd(SRCS_OFF_BRK_STAT, d);
		check("break cleared", d, 8'h00);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			stop_enable_i <= 1'b1;
			short_stop_recovery_i <= ~i[0];
			fire(6'h02);
			repeat (8) @(negedge clk_i);
			check("stopped", obs[3:2], 2'b00);
			apl(4'h4, 4);
			s = refs;
			wait_sig(3, 1'b1, 20000);
			check("recovery", near(refs - s, i ? 4096 : 32, 6), 1'b1);
		end
		// power-on pulse in mid-run restarts the long sequence
		@(posedge clk_i);
		power_on_pulse_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		power_on_pulse_i <= 1'b0;
		s = refs;
		seq(SRCS_CAUSE_RST, 4128, s);
		end_sim();
	end
endmodule : testbench
